// *** ocs_clock_monitor.sv ***
`timescale 1ns/1ns
module ocs_clock_monitor
	import ocs_pkg::*;
#(
	parameter int TIMEOUT_CYC = FAIL_TIMEOUT_CYC
)
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_enable,
	input wire logic i_edge,
	output logic o_fail
);
	localparam int CW = $clog2(TIMEOUT_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

	typedef struct packed
	{
		logic [CW-1:0] cnt;
		logic fail;
	} ocs_mon_t;

	ocs_mon_t q;
	ocs_mon_t d;

	always_comb
	begin
		d = q;
		d.fail = 1'b0;
		if (!i_enable || i_edge)
		begin
			d.cnt = '0;
		end
		else if (q.cnt == LAST)
		begin
			// one pulse per outage, counter parks above the limit
			d.fail = 1'b1; // RQ17
			d.cnt = q.cnt + CW'(1);
		end
		else if (q.cnt < LAST)
		begin
			d.cnt = q.cnt + CW'(1);
		end
		if (!i_resetn)
		begin
			d = '0;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		q <= d;
	end

	assign o_fail = q.fail;
endmodule : ocs_clock_monitor

// *** ocs_osc_clock_select.sv ***
// Function
// RQ1: system clock comes from one of four oscillators only.
// RQ2: multiplier only on primary and fast rc, factors 4, 6, 8.
// RQ3: multiplier output goes through selectable postscaler.
// RQ4: fast rc nominal frequency is 8 MHz.
// RQ5: any of six paths can feed the extra divider.
// RQ6: instruction clock is processor clock divided by two.
// RQ7: osc out pin may carry instruction clock; config bit decides otherwise.
// RQ8: startup source taken from primary mode and oscillator select fields.
// RQ9: erased config gives divided mode fed by fast rc.
// RQ10: switching allowed only when upper switch/monitor bit is zero.
// RQ11: monitor active only when both switch/monitor bits are zero.
// RQ12: oscillator select codes decode per fixed table.
// RQ13: primary mode decode; no multiplier after high-speed crystal.
// RQ14: divider input field resets to fast rc.
// RQ15: control writes need prior unlock.
// RQ16: software trim register for fast rc frequency.
// RQ17: monitor detects loss of active clock.
// RQ18: switch request set by software, cleared by device when done.
// RQ19: lock bit blocks clock and multiplier changes while monitor on.
// RQ20: fail flag set by hardware, cleared only by software.
// RQ21: on failure fall back to fast rc.
// RQ22: source changes only after new source is stable, glitch free.
`timescale 1ns/1ns
module ocs_osc_clock_select
	import ocs_pkg::*;
#(
	parameter int MON_TIMEOUT_CYC = FAIL_TIMEOUT_CYC
)
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [3:0] i_osc_clk_raw,
	input wire logic [1:0] i_primary_mode_cfg,
	input wire logic [2:0] i_startup_osc_select_cfg,
	input wire logic [1:0] i_switch_monitor_cfg,
	input wire logic i_osc_out_pin_function_cfg,
	input wire logic i_ctl_unlock,
	input wire logic i_ctl_wr,
	input wire logic [2:0] i_new_source_select,
	input wire logic i_switch_request,
	input wire logic i_clock_select_lock,
	input wire logic i_clock_fail_clear,
	input wire logic i_div_wr,
	input wire logic [2:0] i_divider_input_select,
	input wire logic [1:0] i_pll_factor,
	input wire logic [1:0] i_postscale_sel,
	input wire logic [7:0] i_osc_divisor,
	input wire logic i_trim_wr,
	input wire logic [5:0] i_rc_trim,
	output logic [2:0] o_current_source_status,
	output logic [2:0] o_new_source_select,
	output logic o_switch_request,
	output logic o_clock_select_lock,
	output logic o_clock_fail_flag,
	output logic [2:0] o_divider_input_select,
	output logic [1:0] o_pll_factor,
	output logic [1:0] o_postscale_sel,
	output logic [7:0] o_osc_divisor,
	output logic [5:0] o_rc_trim,
	output logic [1:0] o_osc_select,
	output logic o_pll_enable,
	output logic o_clk_gate_off,
	output logic o_sys_clk_en,
	output logic o_instr_clk_en,
	output logic o_primary_osc_out_pin,
	output logic o_primary_osc_out_pin_oe,
	output logic o_switch_enabled,
	output logic o_monitor_enabled
);
	typedef struct packed
	{
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] sync3;
		logic [2:0] cur_src;
		logic [2:0] new_src;
		logic sw_req;
		logic clk_lock;
		logic fail_flag;
		logic [2:0] div_in_sel;
		logic [1:0] pll_factor;
		logic [1:0] postscale;
		logic [7:0] divisor;
		logic [5:0] trim;
		logic [1:0] primary_mode;
		logic sw_allowed;
		logic mon_allowed;
		logic pin_fn;
		logic [1:0] unlock_cnt;
		ocs_state_t state;
		logic [3:0] stable_cnt;
		logic [7:0] div_cnt;
		logic sys_en;
		logic instr_phase;
		logic instr_en;
		logic pin_out;
		logic pin_oe;
		logic pll_on;
		logic [1:0] osc_sel;
		logic gate_off;
	} ocs_state_all_t;

	ocs_state_all_t q;
	ocs_state_all_t d;
	logic mon_fail;
	logic [3:0] edges;
	logic mon_edge;

	// physical oscillator behind a select code; divided mode looks through
	function automatic logic [1:0] ocs_phys(input logic [2:0] code, input logic [2:0] divsel);
		logic [2:0] eff;
		eff = (code == SEL_DIV) ? divsel : code; // RQ5
		case (eff)
			SEL_FRC, SEL_FRC_PLL: ocs_phys = OSC_FRC; // RQ12
			SEL_PRI, SEL_PRI_PLL: ocs_phys = OSC_PRI;
			SEL_SEC: ocs_phys = OSC_SEC;
			SEL_LOW_POWER_RC_OSC: ocs_phys = OSC_LOW_POWER_RC_OSC;
			default: ocs_phys = OSC_FRC;
		endcase
	endfunction : ocs_phys

	// multiplier engaged only on the two multiplier paths, never after high-speed crystal
	function automatic logic ocs_pll_path(input logic [2:0] code, input logic [2:0] divsel,
		input logic [1:0] pmode);
		logic [2:0] eff;
		eff = (code == SEL_DIV) ? divsel : code;
		ocs_pll_path = (eff == SEL_FRC_PLL) || ((eff == SEL_PRI_PLL) && (pmode != MODE_HS)); // RQ2 RQ13
	endfunction : ocs_pll_path

	// sync2 vs sync3 only; sync1 stays inside the synchroniser
	assign edges = q.sync2 & ~q.sync3;
	assign mon_edge = edges[q.osc_sel];

	ocs_clock_monitor #(
		.TIMEOUT_CYC(MON_TIMEOUT_CYC)
	) u_monitor (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_enable(q.mon_allowed && !q.gate_off), // RQ11
		.i_edge(mon_edge),
		.o_fail(mon_fail)
	);

	always_comb
	begin
		logic wr_ok;
		logic locked;
		logic tgt_edge;
		wr_ok = 1'b0;
		locked = 1'b0;
		tgt_edge = 1'b0;
		d = q;
		d.sync1 = i_osc_clk_raw;
		d.sync2 = q.sync1;
		d.sync3 = q.sync2;
		d.sys_en = 1'b0;
		d.instr_en = 1'b0;

		if (i_ctl_unlock)
		begin
			d.unlock_cnt = UNLOCK_WINDOW_CYC; // RQ15
		end
		else if (q.unlock_cnt != 2'h0)
		begin
			d.unlock_cnt = q.unlock_cnt - 2'h1;
		end
		wr_ok = i_ctl_wr && (q.unlock_cnt != 2'h0); // RQ15
		locked = q.clk_lock && q.mon_allowed; // RQ19

		if (wr_ok)
		begin
			if (!locked)
			begin
				d.new_src = i_new_source_select; // RQ19
				d.sw_req = q.sw_req | i_switch_request; // RQ18
			end
			d.clk_lock = q.clk_lock | i_clock_select_lock;
		end
		if (i_div_wr)
		begin
			if (!locked)
			begin
				d.div_in_sel = i_divider_input_select; // RQ14
				d.pll_factor = i_pll_factor; // RQ2
			end
			d.postscale = i_postscale_sel; // RQ3
			d.divisor = i_osc_divisor;
		end
		if (i_trim_wr)
		begin
			d.trim = i_rc_trim; // RQ16
		end
		if (i_clock_fail_clear)
		begin
			d.fail_flag = 1'b0; // RQ20
		end

		tgt_edge = edges[ocs_phys(q.new_src, q.div_in_sel)];
		case (q.state)
			ST_RUN:
			begin
				if (q.sw_req)
				begin
					// disallowed, reserved or same-source requests retire at once
					if (!q.sw_allowed || (q.new_src == SEL_RSVD) || (q.new_src == q.cur_src)) // RQ10
					begin
						d.sw_req = 1'b0; // RQ18
					end
					else
					begin
						d.state = ST_WAIT;
						d.stable_cnt = 4'h0;
					end
				end
			end
			ST_WAIT:
			begin
				// a dead target leaves the request pending, software can see it
				if (tgt_edge)
				begin
					d.stable_cnt = q.stable_cnt + 4'h1;
					if (q.stable_cnt == STABLE_EDGES - 4'h1)
					begin
						d.state = ST_SWAP;
						d.gate_off = 1'b1; // RQ22
					end
				end
			end
			ST_SWAP:
			begin
				d.cur_src = q.new_src; // RQ22
				d.sw_req = 1'b0; // RQ18
				d.gate_off = 1'b0;
				d.state = ST_RUN;
			end
			default:
			begin
				d.state = ST_RUN;
				d.gate_off = 1'b0;
			end
		endcase

		// set after the clear so a failure in the clear cycle is kept
		if (mon_fail && q.mon_allowed)
		begin
			d.fail_flag = 1'b1; // RQ20
			d.cur_src = SEL_FRC; // RQ21
			d.sw_req = 1'b0;
			d.gate_off = 1'b0;
			d.state = ST_RUN;
		end

		if (edges[q.osc_sel] && !q.gate_off)
		begin
			if ((q.cur_src == SEL_DIV) && (q.divisor != 8'h00))
			begin
				if (q.div_cnt >= q.divisor - 8'h01)
				begin
					d.div_cnt = 8'h00;
					d.sys_en = 1'b1; // RQ5
				end
				else
				begin
					d.div_cnt = q.div_cnt + 8'h01;
				end
			end
			else
			begin
				d.sys_en = 1'b1; // RQ1
			end
		end
		if (q.sys_en)
		begin
			d.instr_phase = ~q.instr_phase;
			d.instr_en = q.instr_phase; // RQ6
		end
		if (q.instr_en)
		begin
			d.pin_out = ~q.pin_out; // RQ7
		end
		// crystal modes need both pins, internal sources defer to the pin config bit
		case (q.primary_mode)
			MODE_EXT: d.pin_oe = 1'b1; // RQ7
			MODE_INT: d.pin_oe = q.pin_fn; // RQ7
			default: d.pin_oe = 1'b0; // RQ13
		endcase
		d.pll_on = ocs_pll_path(q.cur_src, q.div_in_sel, q.primary_mode);
		d.osc_sel = ocs_phys(q.cur_src, q.div_in_sel); // RQ1

		if (!i_resetn)
		begin
			d = '0;
			// reserved startup code has no path, treated as the erased default
			d.cur_src = (i_startup_osc_select_cfg == SEL_RSVD) ? SEL_DIV : i_startup_osc_select_cfg; // RQ8 RQ9
			d.new_src = d.cur_src;
			d.primary_mode = i_primary_mode_cfg; // RQ8
			d.sw_allowed = ~i_switch_monitor_cfg[1]; // RQ10
			d.mon_allowed = (i_switch_monitor_cfg == SWMON_MONITOR_ON); // RQ11
			d.pin_fn = i_osc_out_pin_function_cfg;
			d.div_in_sel = DIVSEL_RESET; // RQ14 RQ9
			d.pll_factor = PLL_FACTOR_RESET;
			d.postscale = POSTSCALE_RESET;
			d.divisor = DIVISOR_RESET;
			d.trim = TRIM_RESET;
			d.state = ST_RUN;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		q <= d;
	end

	assign o_current_source_status = q.cur_src;
	assign o_new_source_select = q.new_src;
	assign o_switch_request = q.sw_req;
	assign o_clock_select_lock = q.clk_lock;
	assign o_clock_fail_flag = q.fail_flag;
	assign o_divider_input_select = q.div_in_sel;
	assign o_pll_factor = q.pll_factor;
	assign o_postscale_sel = q.postscale;
	assign o_osc_divisor = q.divisor;
	assign o_rc_trim = q.trim;
	assign o_osc_select = q.osc_sel;
	assign o_pll_enable = q.pll_on;
	assign o_clk_gate_off = q.gate_off;
	assign o_sys_clk_en = q.sys_en;
	assign o_instr_clk_en = q.instr_en;
	assign o_primary_osc_out_pin = q.pin_out;
	assign o_primary_osc_out_pin_oe = q.pin_oe;
	assign o_switch_enabled = q.sw_allowed;
	assign o_monitor_enabled = q.mon_allowed;
endmodule : ocs_osc_clock_select

// *** ocs_osc_clock_select_props.sv ***
`timescale 1ns/1ns
module ocs_osc_clock_select_props
	import ocs_pkg::*;
#(
	parameter int MON_TIMEOUT_CYC = FAIL_TIMEOUT_CYC
)
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [1:0] i_primary_mode_cfg,
	input wire logic i_osc_out_pin_function_cfg,
	input wire logic i_ctl_unlock,
	input wire logic i_ctl_wr,
	input wire logic i_clock_fail_clear,
	input wire logic [2:0] o_current_source_status,
	input wire logic [2:0] o_new_source_select,
	input wire logic o_switch_request,
	input wire logic o_clock_select_lock,
	input wire logic o_clock_fail_flag,
	input wire logic [1:0] o_pll_factor,
	input wire logic o_clk_gate_off,
	input wire logic o_primary_osc_out_pin_oe,
	input wire logic o_switch_enabled,
	input wire logic o_monitor_enabled
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_resetn);

	switch_off_a: assert property (!o_switch_enabled && o_switch_request |=> !o_switch_request)
		else $error("request kept with switching off");
	status_cause_a: assert property ($changed(o_current_source_status) |-> $past(o_clk_gate_off) || o_clock_fail_flag)
		else $error("status changed without swap or failure");
	gate_pulse_a: assert property (o_clk_gate_off |=> !o_clk_gate_off && !o_switch_request)
		else $error("swap did not complete");
	fail_hold_a: assert property (o_clock_fail_flag && !i_clock_fail_clear |=> o_clock_fail_flag)
		else $error("fail flag lost without clear");
	fail_fallback_a: assert property ($rose(o_clock_fail_flag) |-> o_current_source_status == SEL_FRC && !o_switch_request)
		else $error("no fallback on failure");
	fail_mon_a: assert property (!o_monitor_enabled |-> !o_clock_fail_flag)
		else $error("failure flagged with monitor off");
	pin_oe_a: assert property ($past(i_resetn) && i_primary_mode_cfg == MODE_INT |-> o_primary_osc_out_pin_oe == i_osc_out_pin_function_cfg)
		else $error("out pin enable wrong");
	lock_hold_a: assert property (o_clock_select_lock && o_monitor_enabled |=> $stable(o_new_source_select) && $stable(o_pll_factor) && o_clock_select_lock)
		else $error("locked selection changed");
	wr_guard_a: assert property (i_ctl_wr && !$past(i_ctl_unlock) && !$past(i_ctl_unlock, 2) |=> $stable(o_new_source_select))
		else $error("write taken without unlock");

	cover property (o_clk_gate_off);
	cover property ($rose(o_clock_fail_flag));
	cover property ($rose(o_clock_select_lock));
endmodule : ocs_osc_clock_select_props

// *** ocs_osc_clock_select_tb.sv ***
`timescale 1ns/1ns
module ocs_osc_clock_select_tb;
	import ocs_pkg::*;
	logic i_ref_clk = 1'h0, i_resetn = 1'h0, i_osc_out_pin_function_cfg = 1'h1;
	logic [3:0] i_osc_clk_raw = 4'h0, run = 4'hF;
	logic [1:0] i_primary_mode_cfg = 2'h3, i_switch_monitor_cfg = 2'h3, i_pll_factor = 2'h0, i_postscale_sel = 2'h0;
	logic [2:0] i_startup_osc_select_cfg = 3'h7, i_new_source_select = 3'h0, i_divider_input_select = 3'h0;
	logic i_ctl_unlock = 1'h0, i_ctl_wr = 1'h0, i_switch_request = 1'h0, i_clock_select_lock = 1'h0;
	logic i_clock_fail_clear = 1'h0, i_div_wr = 1'h0, i_trim_wr = 1'h0;
	logic [7:0] i_osc_divisor = 8'h00, o_osc_divisor;
	logic [5:0] i_rc_trim = 6'h00, o_rc_trim;
	logic [2:0] o_current_source_status, o_new_source_select, o_divider_input_select;
	logic [1:0] o_pll_factor, o_postscale_sel, o_osc_select;
	logic o_switch_request, o_clock_select_lock, o_clock_fail_flag, o_pll_enable, o_clk_gate_off, o_sys_clk_en;
	logic o_instr_clk_en, o_primary_osc_out_pin, o_primary_osc_out_pin_oe, o_switch_enabled, o_monitor_enabled;
	int n_mismatch = 0, n_tests = 0, ns, ni, np;
	logic lp;
	logic [2:0] cd [6] = '{SEL_FRC_PLL, SEL_PRI, SEL_PRI_PLL, SEL_SEC, SEL_LOW_POWER_RC_OSC, SEL_FRC};
	logic [1:0] ox [6] = '{OSC_FRC, OSC_PRI, OSC_PRI, OSC_SEC, OSC_LOW_POWER_RC_OSC, OSC_FRC};
	logic pe [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0};

	// short monitor timeout keeps failure runs brief; raw clocks edge every 2 cycles
	ocs_osc_clock_select #(.MON_TIMEOUT_CYC(20)) dut (.*);

	always #50 i_ref_clk = ~i_ref_clk;
	always @(negedge i_ref_clk) i_osc_clk_raw <= i_osc_clk_raw ^ run;

	task end_of_test;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task chk(input logic [7:0] s, input logic [7:0] e, input string n);
		n_tests++;
		if (s !== e)
		begin
			$display("[FAIL] %s exp %h seen %h", n, e, s);
			n_mismatch++;
		end
	endtask : chk

	task rst(input logic [2:0] sel, input logic [1:0] sm);
		i_startup_osc_select_cfg = sel;
		i_switch_monitor_cfg = sm;
		i_resetn = 1'h0;
		repeat (3) @(negedge i_ref_clk);
		i_resetn = 1'h1;
		repeat (2) @(negedge i_ref_clk);
	endtask : rst

	task ctl(input logic [2:0] c, input logic r, input logic l, input logic u);
		i_ctl_unlock = u;
		@(negedge i_ref_clk);
		i_ctl_unlock = 1'h0;
		i_ctl_wr = 1'h1;
		i_new_source_select = c;
		i_switch_request = r;
		i_clock_select_lock = l;
		@(negedge i_ref_clk);
		i_ctl_wr = 1'h0;
		i_switch_request = 1'h0;
		@(negedge i_ref_clk);
	endtask : ctl

	// no timeout inside the block, so a dead target would stall here until the 200-cycle limit ends the test
	task wt(input bit f);
		int k;
		k = 0;
		while ((f ? o_clock_fail_flag !== 1'h1 : o_switch_request !== 1'h0) && k < 200)
		begin
			@(negedge i_ref_clk);
			k++;
		end
		if (k == 200)
		begin
			n_mismatch++;
			end_of_test();
		end
		repeat (3) @(negedge i_ref_clk);
	endtask : wt

	task sw(input logic [2:0] c);
		ctl(c, 1'h1, 1'h0, 1'h1);
		wt(1'b0);
	endtask : sw

	task div(input logic [1:0] f, input logic [7:0] d);
		i_div_wr = 1'h1;
		i_trim_wr = 1'h1;
		i_divider_input_select = SEL_FRC;
		i_pll_factor = f;
		i_postscale_sel = 2'h2;
		i_osc_divisor = d;
		i_rc_trim = 6'h21;
		@(negedge i_ref_clk);
		i_div_wr = 1'h0;
		i_trim_wr = 1'h0;
		@(negedge i_ref_clk);
	endtask : div

	task cnt;
		ns = 0;
		ni = 0;
		np = 0;
		lp = o_primary_osc_out_pin;
		repeat (400)
		begin
			@(negedge i_ref_clk);
			ns += o_sys_clk_en;
			ni += o_instr_clk_en;
			// pin carries the instruction clock: one toggle per instruction pulse
			np += (o_primary_osc_out_pin !== lp);
			lp = o_primary_osc_out_pin;
		end
	endtask : cnt

	initial
	begin
		rst(SEL_DIV, 2'h3);
		chk(o_current_source_status, SEL_DIV, "erased status");
		chk(o_divider_input_select, SEL_FRC, "div input");
		chk(o_switch_enabled, 1'h0, "sw en off");
		chk(o_monitor_enabled, 1'h0, "mon en off");
		sw(SEL_FRC);
		chk(o_current_source_status, SEL_DIV, "no switch");
		rst(SEL_FRC, 2'h0);
		chk(o_switch_enabled, 1'h1, "sw en");
		chk(o_monitor_enabled, 1'h1, "mon en");
		chk(o_primary_osc_out_pin_oe, 1'h1, "pin oe");
		chk(o_rc_trim, 6'h00, "trim reset");
		ctl(SEL_SEC, 1'h1, 1'h0, 1'h0);
		chk(o_new_source_select, SEL_FRC, "guarded");
		for (int i = 0; i < 6; i++)
		begin
			sw(cd[i]);
			chk(o_current_source_status, cd[i], "status");
			chk(o_osc_select, ox[i], "osc");
			chk(o_pll_enable, pe[i], "pll");
		end
		cnt();
		chk(ns inside {[198:202]}, 1'h1, "sys rate");
		chk(ni inside {[ns / 2 - 1:ns / 2 + 1]}, 1'h1, "instr rate");
		chk(np inside {[ni - 1:ni + 1]}, 1'h1, "pin toggles");
		div(PLL_X4, 8'h04);
		chk(o_rc_trim, 6'h21, "trim");
		chk(o_postscale_sel, 2'h2, "postscale");
		chk(o_osc_divisor, 8'h04, "divisor");
		sw(SEL_DIV);
		cnt();
		chk(ns inside {[48:52]}, 1'h1, "div rate");
		chk(np inside {[ni - 1:ni + 1]}, 1'h1, "div pin toggles");
		sw(SEL_SEC);
		run[2] = 1'h0;
		wt(1'b1);
		chk(o_current_source_status, SEL_FRC, "fallback");
		chk(o_osc_select, OSC_FRC, "fallback osc");
		i_clock_fail_clear = 1'h1;
		@(negedge i_ref_clk);
		i_clock_fail_clear = 1'h0;
		@(negedge i_ref_clk);
		chk(o_clock_fail_flag, 1'h0, "fail clear");
		run[2] = 1'h1;
		ctl(SEL_SEC, 1'h0, 1'h1, 1'h1);
		ctl(SEL_LOW_POWER_RC_OSC, 1'h1, 1'h0, 1'h1);
		chk(o_new_source_select, SEL_SEC, "locked sel");
		chk(o_switch_request, 1'h0, "locked req");
		div(PLL_X8, 8'h00);
		chk(o_pll_factor, PLL_X4, "locked pll");
		end_of_test();
	end
endmodule : ocs_osc_clock_select_tb

bind ocs_osc_clock_select ocs_osc_clock_select_props #(.MON_TIMEOUT_CYC(MON_TIMEOUT_CYC)) u_props (.*);

// *** ocs_pkg.sv ***
package ocs_pkg;
	// oscillator select codes
	localparam logic [2:0] SEL_FRC = 3'h0;
	localparam logic [2:0] SEL_FRC_PLL = 3'h1;
	localparam logic [2:0] SEL_PRI = 3'h2;
	localparam logic [2:0] SEL_PRI_PLL = 3'h3;
	localparam logic [2:0] SEL_SEC = 3'h4;
	localparam logic [2:0] SEL_LOW_POWER_RC_OSC = 3'h5;
	localparam logic [2:0] SEL_RSVD = 3'h6;
	localparam logic [2:0] SEL_DIV = 3'h7;
	// primary mode codes
	localparam logic [1:0] MODE_EXT = 2'h0;
	localparam logic [1:0] MODE_XT = 2'h1;
	localparam logic [1:0] MODE_HS = 2'h2;
	localparam logic [1:0] MODE_INT = 2'h3;
	// multiplier factor codes
	localparam logic [1:0] PLL_X4 = 2'h0;
	localparam logic [1:0] PLL_X6 = 2'h1;
	localparam logic [1:0] PLL_X8 = 2'h2;
	// physical oscillator index, bit position on the raw clock inputs
	localparam logic [1:0] OSC_FRC = 2'h0;
	localparam logic [1:0] OSC_PRI = 2'h1;
	localparam logic [1:0] OSC_SEC = 2'h2;
	localparam logic [1:0] OSC_LOW_POWER_RC_OSC = 2'h3;
	// reset values and monitor-on config code
	localparam logic [2:0] DIVSEL_RESET = SEL_FRC;
	localparam logic [1:0] POSTSCALE_RESET = 2'h0;
	localparam logic [1:0] PLL_FACTOR_RESET = PLL_X4;
	localparam logic [5:0] TRIM_RESET = 6'h00;
	localparam logic [7:0] DIVISOR_RESET = 8'h00;
	localparam logic [1:0] SWMON_MONITOR_ON = 2'h0;
	// timing
	localparam int FRC_NOMINAL_HZ = 8_000_000; // RQ4
	localparam int REF_CLK_HZ = 10_000_000;
	localparam int FAIL_TIMEOUT_NS = 100_000;
	localparam int FAIL_TIMEOUT_CYC = (FAIL_TIMEOUT_NS / 1000) * (REF_CLK_HZ / 1_000_000);
	localparam logic [1:0] UNLOCK_WINDOW_CYC = 2'h2;
	localparam logic [3:0] STABLE_EDGES = 4'h8;

	typedef enum logic [2:0]
	{
		ST_RUN = 3'b001,
		ST_WAIT = 3'b010,
		ST_SWAP = 3'b100
	} ocs_state_t;
endpackage : ocs_pkg
